/* logic/swkcfg_top.sv */
/*
  selective-wake configuration bank with identifier compare and time-out gating.
  assumes frame decoder supplies decoded identifiers, host uses the serial port.
*/
`timescale 1ns/100ps
module swkcfg_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  input wire logic softReset,
  input wire logic restart,
  input wire logic wakeEvent,
  input wire logic selWakeMode,
  input wire logic normalOrStop,
  input wire logic canTimeoutEvent,
  input wire logic canTransmitInput,
  input wire logic rxValid,
  input wire logic [28:0] rxIdent,
  input wire logic rxIde,
  input wire logic rxRtr,
  output logic selectiveWakeEnable,
  output logic oscCalibrationEnable,
  output logic recalUnlocked,
  output logic [7:0] receiverOption,
  output logic [7:0] bitTimeQuantaCount,
  output logic [5:0] samplePointFraction,
  output logic canTimeoutFlag,
  output logic canTimeoutIrq,
  output logic trimRefEdge,
  output logic identMatch
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic idCompare(input logic [28:0] cfg, input logic [28:0] msk,
    input logic [28:0] rx, input logic ide);
    logic [28:0] cmpBits;
    cmpBits = ide ? msk : (msk & {11'h7ff, 18'h00000});
    return ~|(cmpBits & (cfg ^ rx));
  endfunction
  function automatic logic isConfigAddr(input logic [6:0] a);
    return (a >= swkcfg_pkg::ADDR_QUANTA) && (a <= swkcfg_pkg::ADDR_MASK2);
  endfunction
  // ****************************************
  // serial port
  // ****************************************
  logic [6:0] spiAddr;
  logic [7:0] spiWrData;
  logic spiWr;
  logic [7:0] rdData_r;
  swkcfg_spi uSpi (
    .clk(clk),
    .nrst(nrst),
    .sck(sck),
    .csN(csN),
    .mosi(mosi),
    .miso(miso),
    .misoOe(misoOe),
    .rdData(rdData_r),
    .addr(spiAddr),
    .wrData(spiWrData),
    .wrStrobe(spiWr)
  );
  // ****************************************
  // control register
  // ****************************************
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic ctrlWr;
  logic cfgWr;
  logic unlocked;
  assign ctrlWr = spiWr && spiAddr == swkcfg_pkg::ADDR_CTRL;
  assign cfgWr = spiWr && isConfigAddr(spiAddr);
  assign unlocked = ctrl_r[swkcfg_pkg::CTRL_TRIM_HI:swkcfg_pkg::CTRL_TRIM_LO] == swkcfg_pkg::TRIM_UNLOCK;
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (ctrlWr) ctrl_nxt = spiWrData & swkcfg_pkg::CTRL_WMASK;
    // data change or wake clears the valid bit, but a same-cycle set wins
    if ((wakeEvent || cfgWr) && !(ctrlWr && spiWrData[swkcfg_pkg::CTRL_CFG_VALID]))
      ctrl_nxt[swkcfg_pkg::CTRL_CFG_VALID] = 1'b0;
    if (restart) ctrl_nxt = ctrl_r & swkcfg_pkg::CTRL_KEEP_RESTART;
    if (softReset) ctrl_nxt = swkcfg_pkg::RST_CTRL;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) ctrl_r <= swkcfg_pkg::RST_CTRL;
    else ctrl_r <= ctrl_nxt;
  end
  // ****************************************
  // bit timing, identifier and mask registers
  // ****************************************
  logic [7:0] quanta_r;
  logic [7:0] sample_r;
  logic [7:0] id3_r;
  logic [7:0] id2_r;
  logic [7:0] id1_r;
  logic [7:0] id0_r;
  logic [7:0] mask3_r;
  logic [7:0] mask2_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      quanta_r <= swkcfg_pkg::RST_QUANTA;
      sample_r <= swkcfg_pkg::RST_SAMPLE;
      id3_r <= swkcfg_pkg::RST_IDENT;
      id2_r <= swkcfg_pkg::RST_IDENT;
      id1_r <= swkcfg_pkg::RST_IDENT;
      id0_r <= swkcfg_pkg::RST_IDENT;
      mask3_r <= swkcfg_pkg::RST_IDENT;
      mask2_r <= swkcfg_pkg::RST_IDENT;
    end
    else if (softReset)
    begin
      quanta_r <= swkcfg_pkg::RST_QUANTA;
      sample_r <= swkcfg_pkg::RST_SAMPLE;
      id3_r <= swkcfg_pkg::RST_IDENT;
      id2_r <= swkcfg_pkg::RST_IDENT;
      id1_r <= swkcfg_pkg::RST_IDENT;
      id0_r <= swkcfg_pkg::RST_IDENT;
      mask3_r <= swkcfg_pkg::RST_IDENT;
      mask2_r <= swkcfg_pkg::RST_IDENT;
    end
    else if (spiWr)
    begin
      if (spiAddr == swkcfg_pkg::ADDR_QUANTA) quanta_r <= spiWrData;
      else if (spiAddr == swkcfg_pkg::ADDR_SAMPLE) sample_r <= spiWrData & swkcfg_pkg::SAMPLE_WMASK;
      else if (spiAddr == swkcfg_pkg::ADDR_ID3) id3_r <= spiWrData;
      else if (spiAddr == swkcfg_pkg::ADDR_ID2) id2_r <= spiWrData;
      else if (spiAddr == swkcfg_pkg::ADDR_ID1) id1_r <= spiWrData;
      else if (spiAddr == swkcfg_pkg::ADDR_ID0) id0_r <= spiWrData & swkcfg_pkg::ID0_WMASK;
      else if (spiAddr == swkcfg_pkg::ADDR_MASK3) mask3_r <= spiWrData;
      else if (spiAddr == swkcfg_pkg::ADDR_MASK2) mask2_r <= spiWrData;
    end
  end
  // ****************************************
  // receiver option, writable only while unlocked
  // ****************************************
  logic [7:0] rxOpt_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) rxOpt_r <= swkcfg_pkg::RST_RXOPT;
    else if (softReset) rxOpt_r <= swkcfg_pkg::RST_RXOPT;
    else if (spiWr && spiAddr == swkcfg_pkg::ADDR_RXOPT && unlocked)
      rxOpt_r <= spiWrData & swkcfg_pkg::RXOPT_WMASK;
  end
  // ****************************************
  // read mux, registered; unmapped reads return zero
  // ****************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst) rdData_r <= 8'h00;
    else if (spiAddr == swkcfg_pkg::ADDR_CTRL) rdData_r <= ctrl_r & swkcfg_pkg::CTRL_WMASK;
    else if (spiAddr == swkcfg_pkg::ADDR_QUANTA) rdData_r <= quanta_r;
    else if (spiAddr == swkcfg_pkg::ADDR_SAMPLE) rdData_r <= sample_r & swkcfg_pkg::SAMPLE_WMASK;
    else if (spiAddr == swkcfg_pkg::ADDR_ID3) rdData_r <= id3_r;
    else if (spiAddr == swkcfg_pkg::ADDR_ID2) rdData_r <= id2_r;
    else if (spiAddr == swkcfg_pkg::ADDR_ID1) rdData_r <= id1_r;
    else if (spiAddr == swkcfg_pkg::ADDR_ID0) rdData_r <= id0_r & swkcfg_pkg::ID0_WMASK;
    else if (spiAddr == swkcfg_pkg::ADDR_MASK3) rdData_r <= mask3_r;
    else if (spiAddr == swkcfg_pkg::ADDR_MASK2) rdData_r <= mask2_r;
    else if (spiAddr == swkcfg_pkg::ADDR_RXOPT) rdData_r <= rxOpt_r;
    else rdData_r <= 8'h00;
  end
  // ****************************************
  // time-out flag and interrupt gate
  // ****************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      canTimeoutFlag <= 1'b0;
    end
    else if (selWakeMode)
    begin
      // flag only moves in selective-wake mode, holds otherwise
      canTimeoutFlag <= canTimeoutEvent;
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      canTimeoutIrq <= 1'b0;
    end
    else
    begin
      canTimeoutIrq <= canTimeoutEvent && selWakeMode && normalOrStop && ctrl_r[swkcfg_pkg::CTRL_TO_GATE];
    end
  end
  // ****************************************
  // calibration reference: synchronised transmit input, falling edge
  // ****************************************
  logic [2:0] txS_r;
  logic txF_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txS_r <= 3'h7;
      txF_r <= 1'b1;
      trimRefEdge <= 1'b0;
    end
    else
    begin
      txS_r <= {txS_r[1:0], canTransmitInput};
      if (txS_r[1] == txS_r[2]) txF_r <= txS_r[2];
      trimRefEdge <= (txS_r[1] == txS_r[2]) && !txS_r[2] && txF_r && oscCalibrationEnable && recalUnlocked;
    end
  end
  // ****************************************
  // identifier compare and mode outputs
  // ****************************************
  logic [28:0] cfgId;
  logic [28:0] cfgMask;
  assign cfgId = {id3_r, id2_r, id1_r, id0_r[6:2]};
  assign cfgMask = {mask3_r, mask2_r, 13'h0000};
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      identMatch <= 1'b0;
    end
    else
    begin
      identMatch <= rxValid && idCompare(cfgId, cfgMask, rxIdent, rxIde)
        && rxIde == id0_r[swkcfg_pkg::ID0_IDE] && rxRtr == id0_r[swkcfg_pkg::ID0_RTR];
    end
  end
  // mode outputs trail the control register by one cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      selectiveWakeEnable <= 1'b0;
      oscCalibrationEnable <= 1'b0;
      recalUnlocked <= 1'b0;
    end
    else
    begin
      selectiveWakeEnable <= ctrl_r[swkcfg_pkg::CTRL_CFG_VALID];
      oscCalibrationEnable <= ctrl_r[swkcfg_pkg::CTRL_CAL_EN];
      recalUnlocked <= unlocked;
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      receiverOption <= swkcfg_pkg::RST_RXOPT;
      bitTimeQuantaCount <= swkcfg_pkg::RST_QUANTA;
      samplePointFraction <= swkcfg_pkg::RST_SAMPLE[5:0];
    end
    else
    begin
      receiverOption <= rxOpt_r;
      bitTimeQuantaCount <= quanta_r;
      samplePointFraction <= sample_r[5:0];
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_WAKE_OFF: assert property (!ctrl_r[0] |=> !selectiveWakeEnable)
    else $error("selective wake on without config valid");
  AST_CFG_CLEAR: assert property ((cfgWr || wakeEvent) && !ctrlWr |=> !ctrl_r[0] ##1 !selectiveWakeEnable)
    else $error("config valid not cleared");
  AST_LOCKED: assert property (ctrl_r[6:5] != 2'h3 |=> !recalUnlocked)
    else $error("recalibration unlocked without 11");
  AST_RXOPT_LOCK: assert property (spiWr && spiAddr == 7'h35 && !unlocked && !softReset |=> $stable(rxOpt_r))
    else $error("receiver option written while locked");
  AST_TO_GATE: assert property (canTimeoutIrq |-> $past(ctrl_r[4]) && $past(canTimeoutEvent))
    else $error("time-out interrupt while gated");
  AST_TO_HOLD: assert property (!selWakeMode |=> $stable(canTimeoutFlag))
    else $error("time-out flag moved outside wake mode");
  AST_RSV_ZERO: assert property (
    ctrl_r[3:1] == 3'h0 && ($past(spiAddr) != 7'h22 || rdData_r[7:6] == 2'h0)
    && ($past(spiAddr) != 7'h26 || !rdData_r[7]))
    else $error("reserved bit reads one");
  AST_RESET_VAL: assert property (softReset |=> quanta_r == 8'ha0 && sample_r == 8'h33 && id3_r == 8'h00)
    else $error("soft reset values wrong");
  AST_RESTART: assert property (restart && !softReset |=> ctrl_r[3:0] == 4'h0 && ctrl_r[7:4] == $past(ctrl_r[7:4]))
    else $error("restart did not keep upper nibble");
  AST_MATCH_CAUSE: assert property (identMatch |-> $past(rxValid) && $past(rxIde) == $past(id0_r[0]))
    else $error("match without matching frame");
  AST_WAKE_ON: assert property (
    ctrl_r[0]
    |=> selectiveWakeEnable)
    else $error("wake not enabled");
  AST_UNLOCK_ON: assert property (
    ctrl_r[6:5] == 2'h3
    |=> recalUnlocked)
    else $error("unlock missing");
  AST_CAL_ON: assert property (
    ctrl_r[7]
    |=> oscCalibrationEnable)
    else $error("calibration not on");
  AST_CAL_OFF: assert property (
    !ctrl_r[7]
    |=> !oscCalibrationEnable)
    else $error("calibration not off");
  AST_TRIM_GATE: assert property (
    trimRefEdge
    |-> $past(oscCalibrationEnable) && $past(recalUnlocked))
    else $error("trim edge while locked");
  AST_IRQ_ON: assert property (
    canTimeoutEvent && selWakeMode && normalOrStop && ctrl_r[4]
    |=> canTimeoutIrq)
    else $error("time-out interrupt missing");
  AST_FLAG_FOLLOW: assert property (
    selWakeMode
    |=> canTimeoutFlag == $past(canTimeoutEvent))
    else $error("time-out flag stale");
  AST_RSV_REGS: assert property (
    sample_r[7:6] == 2'h0 && !id0_r[7]
    && rxOpt_r[7:1] == 7'h00)
    else $error("reserved bit stored");
  AST_QUANTA_COPY: assert property (
    bitTimeQuantaCount == $past(quanta_r))
    else $error("quanta output stale");
  AST_SAMPLE_COPY: assert property (
    samplePointFraction == $past(sample_r[5:0]))
    else $error("sample output stale");
  AST_ID_RESET: assert property (
    softReset
    |=> id0_r == 8'h00 && mask3_r == 8'h00 && mask2_r == 8'h00)
    else $error("identifier not reset");
  AST_MATCH_RTR: assert property (
    identMatch
    |-> $past(rxRtr) == $past(id0_r[1]))
    else $error("match with wrong remote bit");
  // ****************************************
  // cover points
  // ****************************************
  COV_VALID: cover property (ctrlWr && spiWrData[0] ##2 selectiveWakeEnable);
  COV_MATCH: cover property (identMatch);
  COV_IRQ: cover property (canTimeoutIrq);
  COV_TRIM: cover property (trimRefEdge);
  COV_RESTART: cover property (restart ##1 !ctrl_r[0]);
endmodule // swkcfg_top

/* logic/swkcfg_pkg.sv */
/*
  constants of the selective-wake configuration bank: offsets, field positions,
  reset values, write masks and the serial port frame layout.
  assumes a single 100 MHz clock and the 16-bit serial configuration port.
*/
package swkcfg_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [6:0] ADDR_CTRL = 7'h20;
  localparam logic [6:0] ADDR_QUANTA = 7'h21;
  localparam logic [6:0] ADDR_SAMPLE = 7'h22;
  localparam logic [6:0] ADDR_ID3 = 7'h23;
  localparam logic [6:0] ADDR_ID2 = 7'h24;
  localparam logic [6:0] ADDR_ID1 = 7'h25;
  localparam logic [6:0] ADDR_ID0 = 7'h26;
  localparam logic [6:0] ADDR_MASK3 = 7'h27;
  localparam logic [6:0] ADDR_MASK2 = 7'h28;
  localparam logic [6:0] ADDR_RXOPT = 7'h35;
  // ****************************************
  // field positions and write masks
  // ****************************************
  localparam int CTRL_CFG_VALID = 0;
  localparam int CTRL_TO_GATE = 4;
  localparam int CTRL_TRIM_LO = 5;
  localparam int CTRL_TRIM_HI = 6;
  localparam int CTRL_CAL_EN = 7;
  localparam int ID0_RTR = 1;
  localparam int ID0_IDE = 0;
  localparam logic [1:0] TRIM_UNLOCK = 2'h3;
  localparam logic [7:0] CTRL_WMASK = 8'hf1;
  localparam logic [7:0] CTRL_KEEP_RESTART = 8'hf0;
  localparam logic [7:0] SAMPLE_WMASK = 8'h3f;
  localparam logic [7:0] ID0_WMASK = 8'h7f;
  localparam logic [7:0] RXOPT_WMASK = 8'h01;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_QUANTA = 8'ha0;
  localparam logic [7:0] RST_SAMPLE = 8'h33;
  localparam logic [7:0] RST_IDENT = 8'h00;
  localparam logic [7:0] RST_RXOPT = 8'h00;
  // ****************************************
  // serial frame layout, lsb first
  // ****************************************
  localparam logic [3:0] SPI_WR_BIT = 4'h7;
  localparam logic [3:0] SPI_LAST_BIT = 4'hf;
  localparam logic [3:0] SPI_DATA_FIRST = 4'h8;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'b01,
    SPI_SHIFT = 2'b10
  } swkcfg_spi_e;
endpackage

/* logic/swkcfg_spi.sv */
/*
  serial configuration port slave: 16-bit frames, address and write flag first.
  assumes asynchronous pins, sck much slower than clk.
*/
`timescale 1ns/100ps
module swkcfg_spi (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOe,
  input wire logic [7:0] rdData,
  output logic [6:0] addr,
  output logic [7:0] wrData,
  output logic wrStrobe
);
  // ****************************************
  // pin synchronisers, level taken once stages two and three agree
  // ****************************************
  logic [2:0] sckS_r, csS_r, mosiS_r;
  logic sckF_r, csF_r, mosiF_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sckS_r <= 3'h0;
      csS_r <= 3'h7;
      mosiS_r <= 3'h0;
      sckF_r <= 1'b0;
      csF_r <= 1'b1;
      mosiF_r <= 1'b0;
    end
    else
    begin
      sckS_r <= {sckS_r[1:0], sck};
      csS_r <= {csS_r[1:0], csN};
      mosiS_r <= {mosiS_r[1:0], mosi};
      if (sckS_r[1] == sckS_r[2]) sckF_r <= sckS_r[2];
      if (csS_r[1] == csS_r[2]) csF_r <= csS_r[2];
      if (mosiS_r[1] == mosiS_r[2]) mosiF_r <= mosiS_r[2];
    end
  end
  logic sckRise, sckFall;
  assign sckRise = (sckS_r[1] == sckS_r[2]) && sckS_r[2] && !sckF_r;
  assign sckFall = (sckS_r[1] == sckS_r[2]) && !sckS_r[2] && sckF_r;
  // ****************************************
  // frame shifter
  // ****************************************
  swkcfg_pkg::swkcfg_spi_e state_r;
  logic [3:0] bitCnt_r;
  logic [15:0] rx_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= swkcfg_pkg::SPI_IDLE;
      bitCnt_r <= 4'h0;
      rx_r <= 16'h0000;
      wrStrobe <= 1'b0;
      addr <= 7'h00;
      wrData <= 8'h00;
      miso <= 1'b0;
      misoOe <= 1'b0;
    end
    else
    begin
      wrStrobe <= 1'b0;
      misoOe <= !csF_r;
      case (state_r)
        swkcfg_pkg::SPI_IDLE:
        begin
          bitCnt_r <= 4'h0;
          miso <= 1'b0;
          if (!csF_r) state_r <= swkcfg_pkg::SPI_SHIFT;
        end
        swkcfg_pkg::SPI_SHIFT:
        begin
          if (csF_r) state_r <= swkcfg_pkg::SPI_IDLE;
          else if (sckRise)
          begin
            rx_r[bitCnt_r] <= mosiF_r;
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == swkcfg_pkg::SPI_WR_BIT) addr <= rx_r[6:0];
            // a frame cut short never writes
            if (bitCnt_r == swkcfg_pkg::SPI_LAST_BIT && rx_r[7])
            begin
              wrData <= {mosiF_r, rx_r[14:8]};
              wrStrobe <= 1'b1;
            end
          end
          else if (sckFall && bitCnt_r >= swkcfg_pkg::SPI_DATA_FIRST)
            miso <= rdData[3'(bitCnt_r - swkcfg_pkg::SPI_DATA_FIRST)];
        end
        default: state_r <= swkcfg_pkg::SPI_IDLE;
      endcase
    end
  end
endmodule // swkcfg_spi

/* tb/swkcfg_host_model.sv */
/*
  host model on the serial configuration port: 16-bit frames, lsb first,
  plus the can transmit pin used as trimming reference.
  assumes the bench clock; sck half period of 8 clk, above the 4 clk minimum.
*/
`timescale 1ns/100ps
module swkcfg_host_model (
  input wire logic clk,
  input wire logic miso,
  input wire logic misoOe,
  output logic sck,
  output logic csN,
  output logic mosi,
  output logic canTransmitInput,
  output logic rdDone,
  output logic [7:0] rdByte
);
  // ****************************************
  // frame engine
  // ****************************************
  localparam int HALF = 8;
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    canTransmitInput = 1'b1;
    rdDone = 1'b0;
    rdByte = 8'h00;
  end
  // sck stands low between frames; miso only counts while the port drives it
  task automatic frame(input logic [6:0] a, input logic wr, input logic [7:0] d);
    logic [15:0] f;
    logic [7:0] r;
    f = {d, wr, a};
    r = 8'h00;
    @(posedge clk);
    #1 csN = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      mosi = f[i];
      repeat (HALF) @(posedge clk);
      #1 sck = 1'b1;
      if (i > 7)
        r[i - 8] = miso & misoOe;
      repeat (HALF) @(posedge clk);
      #1 sck = 1'b0;
    end
    repeat (HALF) @(posedge clk);
    #1 csN = 1'b1;
    mosi = ~mosi;
    if (!wr)
    begin
      rdByte = r;
      rdDone = 1'b1;
      @(posedge clk);
      #1 rdDone = 1'b0;
    end
    repeat (HALF) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame(a, 1'b1, d);
  endtask
  task automatic rd(input logic [6:0] a);
    frame(a, 1'b0, 8'h00);
  endtask
  // ****************************************
  // configuration helpers
  // ****************************************
  // config_valid goes last, once the rest of the setup is in place
  task automatic arm(input logic [7:0] ctl);
    frame(swkcfg_pkg::ADDR_CTRL, 1'b1, ctl | 8'h01);
  endtask
  // standard ids ride in bits 28:18; remote frames are never asked for
  task automatic set_ident(input logic [28:0] id, input logic ide);
    wr(swkcfg_pkg::ADDR_ID3, id[28:21]);
    wr(swkcfg_pkg::ADDR_ID2, id[20:13]);
    wr(swkcfg_pkg::ADDR_ID1, id[12:5]);
    wr(swkcfg_pkg::ADDR_ID0, {1'b0, id[4:0], 1'b0, ide});
  endtask
  task automatic trim_pulse;
    @(posedge clk);
    #1 canTransmitInput = 1'b0;
    repeat (8) @(posedge clk);
    #1 canTransmitInput = 1'b1;
  endtask
endmodule // swkcfg_host_model

/* tb/can_selective_wake_config_tb_top.sv */
/*
  self-checking bench for the selective-wake configuration bank.
  assumes the host model owns the serial pins and the transmit pin.
*/
`timescale 1ns/100ps
module can_selective_wake_config_tb_top;
  // ****************************************
  // signals and tables
  // ****************************************
  logic clk, sck, csN, mosi, miso, misoOe, rdDone, flagExp;
  logic nrst = 1'b0, softReset = 1'b0, restart = 1'b0, wakeEvent = 1'b0, selWakeMode = 1'b0;
  logic normalOrStop = 1'b0, canTimeoutEvent = 1'b0, rxValid = 1'b0, rxIde = 1'b0, rxRtr = 1'b0;
  logic canTransmitInput, selectiveWakeEnable, oscCalibrationEnable, recalUnlocked;
  logic canTimeoutFlag, canTimeoutIrq, trimRefEdge, identMatch;
  logic [28:0] rxIdent = 29'h0;
  logic [7:0] receiverOption, bitTimeQuantaCount, rdByte, lfsr, rxOptExp;
  logic [5:0] samplePointFraction;
  logic [7:0] expQ[$];
  int failures = 0, samplesChecked = 0, trimSeen = 0;
  localparam logic [6:0] ADDRS [0:10] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h35, 7'h40};
  localparam logic [7:0] RSTV [0:10] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WMSK [0:10] = '{8'hf1, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h01, 8'h00};
  localparam logic [28:0] ID_CFG = 29'h15a5c3e9;
  swkcfg_top uut (.clk(clk), .nrst(nrst), .sck(sck), .csN(csN), .mosi(mosi), .miso(miso), .misoOe(misoOe),
    .softReset(softReset), .restart(restart), .wakeEvent(wakeEvent), .selWakeMode(selWakeMode),
    .normalOrStop(normalOrStop), .canTimeoutEvent(canTimeoutEvent), .canTransmitInput(canTransmitInput),
    .rxValid(rxValid), .rxIdent(rxIdent), .rxIde(rxIde), .rxRtr(rxRtr), .selectiveWakeEnable(selectiveWakeEnable),
    .oscCalibrationEnable(oscCalibrationEnable), .recalUnlocked(recalUnlocked), .receiverOption(receiverOption),
    .bitTimeQuantaCount(bitTimeQuantaCount), .samplePointFraction(samplePointFraction),
    .canTimeoutFlag(canTimeoutFlag), .canTimeoutIrq(canTimeoutIrq), .trimRefEdge(trimRefEdge),
    .identMatch(identMatch));
  swkcfg_host_model host (.clk(clk), .miso(miso), .misoOe(misoOe), .sck(sck), .csN(csN), .mosi(mosi),
    .canTransmitInput(canTransmitInput), .rdDone(rdDone), .rdByte(rdByte));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // inputs always move 1 ns after the edge, never on it
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_out(input string name, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reset_check;
    check_out("quanta", 8'ha0, bitTimeQuantaCount);
    check_out("sample", 8'h33, {2'b00, samplePointFraction});
    check_out("swkEnable", 8'h00, {7'h00, selectiveWakeEnable});
    for (int i = 0; i < 11; i++)
      rd_exp(ADDRS[i], RSTV[i]);
  endtask
  task automatic trim_check(input logic [7:0] ctl, input logic exp);
    host.wr(ADDRS[0], ctl);
    trimSeen = 0;
    host.trim_pulse();
    step(20);
    check_out("trimEdge", {7'h00, exp}, (trimSeen == 1) ? 8'h01 : 8'h00);
  endtask
  task automatic match_case(input logic [28:0] id, input logic ide, input logic rtr, input logic exp);
    step(1);
    rxIdent = id;
    rxIde = ide;
    rxRtr = rtr;
    rxValid = 1'b1;
    step(1);
    rxValid = 1'b0;
    check_out("identMatch", {7'h00, exp}, {7'h00, identMatch});
  endtask
  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge clk)
  begin
    if (rdDone === 1'b1)
    begin
      if (expQ.size() == 0)
        check_out("readQueue", 8'h00, rdByte);
      else
        check_out("readData", expQ.pop_front(), rdByte);
    end
    if (trimRefEdge === 1'b1)
      trimSeen++;
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    print_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    lfsr = 8'h36;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    step(4);
    reset_check();
    for (int i = 1; i < 9; i++)
    begin
      host.arm(8'h10);
      check_out("swkEnable", 8'h01, {7'h00, selectiveWakeEnable});
      lfsr = lfsr_next(lfsr);
      host.wr(ADDRS[i], lfsr);
      check_out("swkEnable", 8'h00, {7'h00, selectiveWakeEnable});
      rd_exp(ADDRS[i], lfsr & WMSK[i]);
      if (i == 1)
        check_out("quanta", lfsr, bitTimeQuantaCount);
      if (i == 2)
        check_out("sample", lfsr & 8'h3f, {2'b00, samplePointFraction});
    end
    rd_exp(ADDRS[0], 8'h10);
    host.wr(ADDRS[10], 8'hff);
    rd_exp(ADDRS[10], 8'h00);
    host.arm(8'hfe);
    rd_exp(ADDRS[0], 8'hf1);
    wakeEvent = 1'b1;
    step(1);
    wakeEvent = 1'b0;
    step(3);
    check_out("swkEnable", 8'h00, {7'h00, selectiveWakeEnable});
    host.arm(8'hfe);
    restart = 1'b1;
    step(1);
    restart = 1'b0;
    step(3);
    rd_exp(ADDRS[0], 8'hf0);
    check_out("oscCal", 8'h01, {7'h00, oscCalibrationEnable});
    rxOptExp = 8'h00;
    for (int k = 0; k < 4; k++)
    begin
      host.wr(ADDRS[0], {1'b1, k[1:0], 5'h00});
      check_out("unlocked", {7'h00, k == 3}, {7'h00, recalUnlocked});
      check_out("oscCal", 8'h01, {7'h00, oscCalibrationEnable});
      host.wr(ADDRS[9], ~rxOptExp);
      if (k == 3)
        rxOptExp = 8'h01;
      rd_exp(ADDRS[9], rxOptExp);
    end
    host.wr(ADDRS[0], 8'h00);
    check_out("oscCal", 8'h00, {7'h00, oscCalibrationEnable});
    host.wr(ADDRS[9], 8'hfe);
    check_out("rxOption", 8'h01, receiverOption);
    trim_check(8'he0, 1'b1);
    trim_check(8'hc0, 1'b0);
    trim_check(8'h60, 1'b0);
    flagExp = 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      host.wr(ADDRS[0], {3'b000, c[0], 4'h0});
      step(1);
      selWakeMode = c[1];
      normalOrStop = c[2];
      canTimeoutEvent = 1'b1;
      step(4);
      if (c[1])
        flagExp = 1'b1;
      check_out("toIrq", {7'h00, c[0] & c[1] & c[2]}, {7'h00, canTimeoutIrq});
      check_out("toFlag", {7'h00, flagExp}, {7'h00, canTimeoutFlag});
      canTimeoutEvent = 1'b0;
      if (c[2])
        selWakeMode = 1'b0;
      step(4);
      if (c[1] && !c[2])
        flagExp = 1'b0;
      check_out("toFlag", {7'h00, flagExp}, {7'h00, canTimeoutFlag});
    end
    host.wr(ADDRS[7], 8'hff);
    host.wr(ADDRS[8], 8'hff);
    host.set_ident(ID_CFG, 1'b1);
    host.arm(8'h00);
    match_case(ID_CFG, 1'b1, 1'b0, 1'b1);
    match_case(ID_CFG ^ 29'h00100000, 1'b1, 1'b0, 1'b0);
    match_case(ID_CFG ^ 29'h00000020, 1'b1, 1'b0, 1'b1);
    match_case(ID_CFG, 1'b1, 1'b1, 1'b0);
    match_case(ID_CFG, 1'b0, 1'b0, 1'b0);
    host.set_ident(ID_CFG, 1'b0);
    host.wr(ADDRS[7], 8'h7f);
    host.arm(8'h00);
    match_case(ID_CFG ^ 29'h00020000, 1'b0, 1'b0, 1'b1);
    match_case(ID_CFG ^ 29'h00040000, 1'b0, 1'b0, 1'b0);
    match_case(ID_CFG ^ 29'h10000000, 1'b0, 1'b0, 1'b1);
    softReset = 1'b1;
    step(1);
    softReset = 1'b0;
    step(3);
    reset_check();
    step(20);
    check_out("pending", 8'h00, 8'(expQ.size()));
    print_verdict();
  end
endmodule // can_selective_wake_config_tb_top
